// >>> design/perf_event_counters.sv
// Two performance event counters with delayed overflow interrupt
//
// Notes on behaviour
// - Code 1010 counts every cycle; 110X every second non-issue cycle.
// - Code 111X counts pin events sampled at a chosen interval.
// - Counter one range: write bit 0, read bit 2; 2^12 clear, 2^8 set.
// - Counter zero range: write bit 3, read bit 1; 2^16 when clear.
// - Counters zero at power-up; nothing else, not reselection, clears them.
// - No software path reads a partial count; only overflows report.
// - Counting ignores interrupt enables; first overflow may come early.
// - Every execution attempt counts, even one aborted late by an error.
// - Interrupt request rises exactly six cycles after the overflowing event.
// - Events after an overflow keep counting toward the next overflow.
// - Request stays pending while disabled; removed only by a clear write.
// - At most twelve instructions complete before interrupt service.
// - Counting I-cache misses, none complete; saved PC is that last miss.
// - Counting branch mispredictions, at most two instructions complete.
// - Code 1011 counts every cycle in privileged firmware mode.
`timescale 1ns/1ps
`default_nettype none

module perf_event_counters #(
    parameter int CNT_W = 16,
    parameter int C0_SHORT_BITS = 8,
    parameter int EXT_INT_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Register port
    input wire perf_pkg::reg_req_t reg_req,
    output logic [31:0] rd_data,
    // Event sources
    input wire perf_pkg::pipe_events_t pipe_events,
    input wire logic external_event_input,
    // Interrupt
    output logic irq
);
    import perf_pkg::*;

    perf_ctrl_t ctrl_reg;
    perf_ctrl_t ctrl_next;
    logic [NUM_CNT-1:0] status_reg;
    logic [NUM_CNT-1:0] status_next;
    logic [NUM_CNT-1:0] enable_reg;
    logic [NUM_CNT-1:0] enable_next;
    logic [EXT_INT_W-1:0] ext_interval_reg;
    logic [EXT_INT_W-1:0] ext_interval_next;
    logic [EXT_INT_W-1:0] tick_cnt_reg;
    logic [EXT_INT_W-1:0] tick_cnt_next;
    logic [31:0] rd_data_reg;
    logic [31:0] rd_data_next;
    logic irq_reg;
    logic irq_next;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_tick;
    logic ext_event;

    logic [CNT_W-1:0] cnt_reg [NUM_CNT];
    logic [CNT_W-1:0] cnt_next [NUM_CNT];
    logic [NUM_CNT-1:0] half_reg;
    logic [NUM_CNT-1:0] half_next;
    logic [NUM_CNT-1:0] ovf;
    logic [OVF_PIPE_LEN-1:0] ovf_pipe_reg [NUM_CNT];
    logic [OVF_PIPE_LEN-1:0] ovf_pipe_next [NUM_CNT];
    logic [NUM_CNT-1:0] ovf_late;

    // Register decode
    wire logic hit_ctrl;
    wire logic hit_status;
    wire logic hit_clear;
    wire logic hit_enable;
    wire logic hit_ext;
    wire logic wr_ctrl;
    wire logic wr_clear;
    wire logic wr_enable;
    wire logic wr_ext;
    wire logic [NUM_CNT-1:0] clear_mask;

    // Read words, one per readable register
    logic [31:0] ctrl_rd_word;
    wire logic [31:0] status_rd_word;
    wire logic [31:0] enable_rd_word;
    wire logic [31:0] ext_rd_word;

    assign hit_ctrl = (reg_req.addr == ADDR_CTRL);
    assign hit_status = (reg_req.addr == ADDR_STATUS);
    assign hit_clear = (reg_req.addr == ADDR_CLEAR);
    assign hit_enable = (reg_req.addr == ADDR_ENABLE);
    assign hit_ext = (reg_req.addr == ADDR_EXT_INTERVAL);
    assign wr_ctrl = reg_req.wr && hit_ctrl;
    assign wr_clear = reg_req.wr && hit_clear;
    assign wr_enable = reg_req.wr && hit_enable;
    assign wr_ext = reg_req.wr && hit_ext;
    assign clear_mask = wr_clear ? reg_req.wdata[NUM_CNT-1:0] : '0;

    // Range bits are written and read back at different positions
    assign ctrl_next = wr_ctrl ? perf_ctrl_t'{
        sel1: reg_req.wdata[SEL1_LSB +: SEL_W],
        sel0: reg_req.wdata[SEL0_LSB +: SEL_W],
        c0_range: reg_req.wdata[WR_C0_RANGE_BIT],
        c1_range: reg_req.wdata[WR_C1_RANGE_BIT]
    } : ctrl_reg;

    always_comb begin
        ctrl_rd_word = '0;
        ctrl_rd_word[RD_C1_RANGE_BIT] = ctrl_reg.c1_range;
        ctrl_rd_word[RD_C0_RANGE_BIT] = ctrl_reg.c0_range;
        ctrl_rd_word[SEL0_LSB +: SEL_W] = ctrl_reg.sel0;
        ctrl_rd_word[SEL1_LSB +: SEL_W] = ctrl_reg.sel1;
    end

    assign status_rd_word = {{(32-NUM_CNT){1'b0}}, status_reg};
    assign enable_rd_word = {{(32-NUM_CNT){1'b0}}, enable_reg};
    assign ext_rd_word = {{(32-EXT_INT_W){1'b0}}, ext_interval_reg};

    // Counts themselves have no read path; unmapped and clear read zero
    always_comb begin
        rd_data_next = '0;
        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_CTRL: begin
                    rd_data_next = ctrl_rd_word;
                end
                ADDR_STATUS: begin
                    rd_data_next = status_rd_word;
                end
                ADDR_ENABLE: begin
                    rd_data_next = enable_rd_word;
                end
                ADDR_EXT_INTERVAL: begin
                    rd_data_next = ext_rd_word;
                end
                default: begin
                    rd_data_next = '0;
                end
            endcase
        end
    end

    assign enable_next = wr_enable ? reg_req.wdata[NUM_CNT-1:0] : enable_reg;
    assign ext_interval_next = wr_ext ?
        reg_req.wdata[EXT_INT_W-1:0] : ext_interval_reg;

    // External pin sampling every interval+1 cycles
    assign ext_tick = (tick_cnt_reg == '0);
    assign tick_cnt_next = ext_tick ? ext_interval_reg : tick_cnt_reg - 1'b1;
    assign ext_event = ext_tick && ext_sync_reg;

    // Per-cycle decision whether the selected source counts
    function automatic logic src_counts(
        input logic [3:0] sel,
        input logic half,
        input pipe_events_t ev,
        input logic ext_ev
    );
        logic hit;
        hit = 1'b0;
        if (sel == SEL_TOTAL_CYCLES) begin
            hit = 1'b1;
        end else if (sel == SEL_PRIV_MODE) begin
            hit = ev.priv_mode;
        end else if (sel[3:1] == SEL_NON_ISSUE_HI) begin
            hit = ev.no_issue && half;
        end else if (sel[3:1] == SEL_EXTERNAL_HI) begin
            hit = ext_ev;
        end
        return hit;
    endfunction

    // Last count value before the wrap, as a mask of the range width
    function automatic logic [CNT_W-1:0] range_top(input int bits);
        return {CNT_W{1'b1}} >> (CNT_W - bits);
    endfunction

    wire logic [CNT_W-1:0] top [NUM_CNT];
    wire logic [3:0] sel [NUM_CNT];

    assign top[0] = ctrl_reg.c0_range ?
        range_top(C0_SHORT_BITS) : range_top(C0_LONG_BITS);
    assign top[1] = ctrl_reg.c1_range ?
        range_top(C1_SHORT_BITS) : range_top(C1_LONG_BITS);
    assign sel[0] = ctrl_reg.sel0;
    assign sel[1] = ctrl_reg.sel1;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            wire logic inc;
            wire logic at_top;

            // Pipeline events are attempts, not retirements, so an
            // aborted attempt is counted and its reissue counts again
            assign inc = src_counts(sel[gi], half_reg[gi], pipe_events,
                ext_event);
            // Shrinking the range below the current count wraps at the next counted event
            assign at_top = (cnt_reg[gi] >= top[gi]);
            assign ovf[gi] = inc && at_top;
            // Nothing but an event moves the count; no reselect clear
            assign cnt_next[gi] = !inc ? cnt_reg[gi] :
                at_top ? '0 : cnt_reg[gi] + 1'b1;
            // Halving phase toggles on each non-issue cycle while a 110X code is selected
            assign half_next[gi] = (sel[gi][3:1] == SEL_NON_ISSUE_HI &&
                pipe_events.no_issue) ? !half_reg[gi] : half_reg[gi];
            assign ovf_pipe_next[gi] =
                {ovf_pipe_reg[gi][OVF_PIPE_LEN-2:0], ovf[gi]};
            assign ovf_late[gi] = ovf_pipe_reg[gi][OVF_PIPE_LEN-1];

            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    cnt_reg[gi] <= '0;
                    half_reg[gi] <= 1'b0;
                    ovf_pipe_reg[gi] <= '0;
                end else begin
                    cnt_reg[gi] <= cnt_next[gi];
                    half_reg[gi] <= half_next[gi];
                    ovf_pipe_reg[gi] <= ovf_pipe_next[gi];
                end
            end
        end
    endgenerate

    // Sticky requests: a new overflow beats a simultaneous clear
    assign status_next = (status_reg & ~clear_mask) | ovf_late;
    // The fixed short delay is what keeps the pipeline's run-on small:
    // at most twelve completions, two after a mispredict, none after
    // an I-cache miss, whose address the exception logic then saves
    assign irq_next = |(status_reg & enable_reg);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= '{sel1: SEL_RESET, sel0: SEL_RESET,
                c0_range: 1'b0, c1_range: 1'b0};
            status_reg <= '0;
            enable_reg <= '0;
            ext_interval_reg <= EXT_INT_W'(EXT_INTERVAL_RESET);
            tick_cnt_reg <= '0;
            rd_data_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            enable_reg <= enable_next;
            ext_interval_reg <= ext_interval_next;
            tick_cnt_reg <= tick_cnt_next;
            rd_data_reg <= rd_data_next;
            irq_reg <= irq_next;
        end
    end

    // Pin synchroniser
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg <= external_event_input;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    assign rd_data = rd_data_reg;
    assign irq = irq_reg;

endmodule

`default_nettype wire

// >>> design/perf_pkg.sv
// Package of constants and carrier types for the performance event counters
package perf_pkg;

    // Register word offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_EXT_INTERVAL = 8'h10;

    // Control word, write layout
    localparam int WR_C1_RANGE_BIT = 0;
    localparam int WR_C0_RANGE_BIT = 3;
    // Control word, read layout
    localparam int RD_C0_RANGE_BIT = 1;
    localparam int RD_C1_RANGE_BIT = 2;
    // Event select fields, same place for write and read
    localparam int SEL0_LSB = 4;
    localparam int SEL1_LSB = 8;
    localparam int SEL_W = 4;

    // Event select codes (X marks a don't care bit)
    localparam logic [3:0] SEL_TOTAL_CYCLES = 4'ha;
    localparam logic [3:0] SEL_PRIV_MODE = 4'hb;
    localparam logic [2:0] SEL_NON_ISSUE_HI = 3'h6;
    localparam logic [2:0] SEL_EXTERNAL_HI = 3'h7;

    // Overflow ranges as powers of two
    localparam int C1_LONG_BITS = 12;
    localparam int C1_SHORT_BITS = 8;
    localparam int C0_LONG_BITS = 16;

    // Overflow to interrupt output delay in cycles
    localparam int IRQ_DELAY_CYC = 6;
    // Status set and interrupt register take the last two cycles
    localparam int OVF_PIPE_LEN = IRQ_DELAY_CYC - 2;

    // Reset values
    localparam logic [7:0] EXT_INTERVAL_RESET = 8'h00;
    localparam logic [3:0] SEL_RESET = 4'ha;

    localparam int NUM_CNT = 2;

    typedef struct packed {
        logic [3:0] sel1;
        logic [3:0] sel0;
        logic c0_range;
        logic c1_range;
    } perf_ctrl_t;

    typedef struct packed {
        logic no_issue;
        logic priv_mode;
    } pipe_events_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// >>> tb/perf_event_src.sv
// Event source model: pipeline event levels and the external event pin
`timescale 1ns/1ps
`default_nettype none
module perf_event_src (
    // Clock
    input wire logic clk_sys,
    // Event lines
    output perf_pkg::pipe_events_t pipe_events,
    output logic external_event_input
);
    import perf_pkg::*;
    initial begin
        pipe_events = '0;
        external_event_input = 1'b0;
    end
    task automatic drive(input int kind, input logic v);
        case (kind)
            0: pipe_events.no_issue <= v;
            1: pipe_events.priv_mode <= v;
            default: external_event_input <= v;
        endcase
    endtask
    // Holds one line high for n whole cycles, then idles it low
    task automatic emit(input int kind, input int n);
        @(posedge clk_sys);
        drive(kind, 1'b1);
        repeat (n) @(posedge clk_sys);
        drive(kind, 1'b0);
    endtask
endmodule
`default_nettype wire

// >>> tb/perf_event_counters_properties.sv
// Port-level checker for the performance event counters
`timescale 1ns/1ps
`default_nettype none
module perf_event_counters_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire perf_pkg::reg_req_t reg_req,
    input wire logic [31:0] rd_data,
    input wire perf_pkg::pipe_events_t pipe_events,
    input wire logic external_event_input,
    input wire logic irq
);
    import perf_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Shadow of what software last wrote to control and enable
    logic [9:0] ctl_reg;
    logic [1:0] en_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl_reg <= 10'h2a8;
            en_reg <= 2'h0;
        end else if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
            ctl_reg <= {reg_req.wdata[11:4], reg_req.wdata[3:3],
                reg_req.wdata[0:0]};
        end else if (reg_req.wr && reg_req.addr == ADDR_ENABLE) begin
            en_reg <= reg_req.wdata[1:0];
        end
    end
    property p_rd_idle;
        !$past(reg_req.rd) |-> rd_data == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray data");
    property p_ctrl_rd;
        reg_req.rd && reg_req.addr == ADDR_CTRL |=> rd_data[11:4] ==
            $past(ctl_reg[9:2]) &&
            rd_data[2:1] == {$past(ctl_reg[0]), $past(ctl_reg[1])};
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl layout");
    property p_rd_clear;
        reg_req.rd && reg_req.addr == ADDR_CLEAR |=> rd_data == 32'h0;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("clear read");
    property p_rd_status;
        reg_req.rd && reg_req.addr == ADDR_STATUS |=> rd_data[31:2] == 30'h0;
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("count seen");
    property p_rd_enable;
        reg_req.rd && reg_req.addr == ADDR_ENABLE |=>
            rd_data == {30'h0, $past(en_reg)};
    endproperty
    a_rd_enable: assert property (p_rd_enable) else $error("enable read");
    property p_irq_en;
        irq |-> $past(en_reg) != 2'h0;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq disabled");
    property p_irq_fall;
        $fell(irq) |-> $past(reg_req.wr && (reg_req.addr == ADDR_CLEAR ||
            reg_req.addr == ADDR_ENABLE), 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
    property p_pwrup;
        $rose(rstn) |-> !irq [*8];
    endproperty
    a_pwrup: assert property (p_pwrup) else $error("irq at start");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Testbench for the performance event counters
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    n_errors++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
    import perf_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    reg_req_t reg_req = '0;
    logic [31:0] rd_data;
    pipe_events_t pipe_events;
    logic external_event_input;
    logic irq;
    int n_errors = 0;
    int comparisons = 0;
    always #2.5 clk_sys = ~clk_sys;
    perf_event_counters #(.C0_SHORT_BITS(4)) uut (.clk_sys(clk_sys),
        .rstn(rstn), .reg_req(reg_req), .rd_data(rd_data),
        .pipe_events(pipe_events),
        .external_event_input(external_event_input), .irq(irq));
    perf_event_src src (.clk_sys(clk_sys), .pipe_events(pipe_events),
        .external_event_input(external_event_input));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1 `CHECK("rd_data", exp, rd_data)
    endtask
    // Single events until the overflow shows: the count is then zero,
    // whatever it held before, since it can never be read
    task automatic sync(input int kind, input int b);
        wr(ADDR_CLEAR, 32'h3);
        wr(ADDR_ENABLE, 32'h1 << b);
        for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
            src.emit(kind, 1);
            repeat (10) @(posedge clk_sys);
        end
        wr(ADDR_CLEAR, 32'h3);
    endtask
    // n events; an overflow by the last must raise irq six cycles on
    task automatic run(input int kind, input int n, input logic ovf);
        src.emit(kind, n);
        repeat (4) @(posedge clk_sys);
        #1 `CHECK("irq early", 1'b0, irq)
        @(posedge clk_sys);
        #1 `CHECK("irq", ovf, irq)
        wr(ADDR_CLEAR, 32'h3);
    endtask
    task automatic ext(input int n, input logic [31:0] st);
        src.emit(2, n);
        repeat (12) @(posedge clk_sys);
        rd(ADDR_STATUS, st);
    endtask
    task automatic results;
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0aa0);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_ENABLE, 32'h0);
        rd(ADDR_CLEAR, 32'h0);
        rd(8'h20, 32'h0);
        wr(ADDR_CTRL, 32'h0000_0b01);
        rd(ADDR_CTRL, 32'h0000_0b04);
        sync(1, 1);
        run(1, 255, 1'b0);
        run(1, 1, 1'b1);
        run(1, 200, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0b01);
        run(1, 56, 1'b1);
        // Masked overflow must wait as a pending request
        wr(ADDR_ENABLE, 32'h0);
        src.emit(1, 256);
        repeat (10) @(posedge clk_sys);
        #1 `CHECK("irq masked", 1'b0, irq)
        rd(ADDR_STATUS, 32'h2);
        wr(ADDR_ENABLE, 32'h2);
        @(posedge clk_sys);
        #1 `CHECK("irq pending", 1'b1, irq)
        wr(ADDR_CTRL, 32'h0000_00c8);
        sync(0, 0);
        run(0, 31, 1'b0);
        run(0, 1, 1'b1);
        wr(ADDR_CTRL, 32'h0000_00e8);
        sync(2, 0);
        ext(16, 32'h1);
        wr(ADDR_CLEAR, 32'h3);
        wr(ADDR_EXT_INTERVAL, 32'h3);
        ext(60, 32'h0);
        ext(4, 32'h1);
        results();
    end
endmodule
bind perf_event_counters perf_event_counters_checker chk (.clk_sys(clk_sys),
    .rstn(rstn), .reg_req(reg_req), .rd_data(rd_data),
    .pipe_events(pipe_events),
    .external_event_input(external_event_input), .irq(irq));
`default_nettype wire
